//--- common/iss_pkg.sv
// constants for the initiator selection status block
// assumes a single 125 MHz clock domain and a byte-wide register port
//
// Behaviour
// (R1) disconnect, timeout or arbitration end: step 0, cause 20
// (R2) select-with-attention complete: step 4, cause 18
// (R3) premature phase change in command: step 3, cause 18
// (R4) plain selection, no command phase: step 2, cause 18
// (R5) one message byte, release attention; no command: step 2
// (R6) attention, no message-out: step 0, attention kept
// (R7) three-byte attention complete: step 4, cause 18
// (R8) three bytes then release; early exit: step 2
// (R9) three-byte, no message-out: step 0, attention kept
// (R10) attention-and-stop, no message-out: step 0, attention kept
// (R11) step register updated after each intermediate step
// (R12) cause read clears cause, status and step
// (R13) disconnect flag set on disconnect or timeout
// (R14) interrupt rises with final step and cause
`default_nettype none
package iss_pkg;
   // register offsets
   localparam logic [7:0] OFS_CMD   = 8'h03;
   localparam logic [7:0] OFS_MAIN  = 8'h04;
   localparam logic [7:0] OFS_CAUSE = 8'h05;
   localparam logic [7:0] OFS_STEP  = 8'h06;
   localparam logic [7:0] OFS_IST   = 8'h08;
   localparam logic [7:0] OFS_IMASK = 8'h09;
   // values after reset
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [2:0] RST_STEP  = 3'h0;
   // cause bytes
   localparam logic [7:0] CAUSE_DISC = 8'h20;
   localparam logic [7:0] CAUSE_SRSO = 8'h18;
   // step codes
   localparam logic [2:0] STEP_SEL  = 3'h0;
   localparam logic [2:0] STEP_STOP = 3'h1;
   localparam logic [2:0] STEP_MSG  = 3'h2;
   localparam logic [2:0] STEP_CMD  = 3'h3;
   localparam logic [2:0] STEP_DONE = 3'h4;
   // bus phases {msg, c/d, i/o}
   localparam logic [2:0] PH_CMD    = 3'h2;
   localparam logic [2:0] PH_MSGOUT = 3'h6;
   // message byte count of the three-byte variant
   localparam logic [1:0] MSG3_BYTES = 2'h3;
   // field positions
   localparam int MAIN_INT_BIT = 7;
   localparam int CMD_BUSY_BIT = 7;
   localparam int IRQ_END = 0;
   localparam int IRQ_DISC = 1;
   localparam int IRQ_W = 2;

   typedef enum logic [1:0] {
      ISS_PLAIN,
      ISS_ATN,
      ISS_ATN3,
      ISS_STOP
   } iss_kind_e;
endpackage : iss_pkg
`default_nettype wire

//--- common/iss_irq_if.sv
// signals between the status core and the interrupt unit
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface iss_irq_if;
   import iss_pkg::*;
   logic [IRQ_W-1:0] evt;
   logic             wr_stat;
   logic             wr_mask;
   logic [IRQ_W-1:0] wdata;
   logic [IRQ_W-1:0] stat;
   logic [IRQ_W-1:0] mask;
   logic             irq;

   modport core (output evt, wr_stat, wr_mask, wdata,
                 input stat, mask, irq);
   modport unit (input evt, wr_stat, wr_mask, wdata,
                 output stat, mask, irq);
endinterface : iss_irq_if
`default_nettype wire

//--- verilog/iss_irq.sv
// sticky interrupt status with write-one-to-clear and a mask
// assumes events are one-cycle pulses on clk
`timescale 1ns/1ps
`default_nettype none
module iss_irq
   import iss_pkg::*;
(
   input  wire logic clk,
   input  wire logic nrst,
   iss_irq_if.unit   bus
);
   logic [IRQ_W-1:0] stat_r;
   logic [IRQ_W-1:0] mask_r;

   // set wins over a clear in the same cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stat_r <= '0;
      end else if (bus.wr_stat) begin
         stat_r <= (stat_r & ~bus.wdata) | bus.evt;
      end else begin
         stat_r <= stat_r | bus.evt;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mask_r <= '0;
      end else if (bus.wr_mask) begin
         mask_r <= bus.wdata;
      end
   end

   assign bus.stat = stat_r;
   assign bus.mask = mask_r;
   assign bus.irq  = |(stat_r & mask_r);
endmodule : iss_irq
`default_nettype wire

//--- verilog/iss_top.sv
// initiator selection sequencer with step and cause reporting
// assumes bus events arrive as one-cycle pulses synchronous to clk
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module iss_top
   import iss_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rdata,
   input  wire logic       sel_done,
   input  wire logic       disc_evt,
   input  wire logic       req_evt,
   input  wire logic [2:0] bus_phase,
   input  wire logic       byte_sent,
   input  wire logic       cdb_last,
   output logic            atn_o,
   output logic            busy_o,
   output logic            irq_o
);
   typedef enum logic [2:0] {
      S_IDLE,
      S_SEL,
      S_MSGW,
      S_MSG,
      S_CMDW,
      S_CMD
   } iss_state_e;

   iss_state_e  state_r;
   iss_state_e  state_nxt;
   iss_kind_e   kind_r;
   logic [7:0]  cause_r;
   logic [2:0]  step_r;
   logic [7:0]  main_r;
   logic [1:0]  cnt_r;
   logic [1:0]  cnt_nxt;
   logic        atn_r;
   logic        atn_nxt;
   logic        start;
   logic        cause_rd;
   logic        fin;
   logic [2:0]  fin_step;
   logic [7:0]  fin_cause;
   logic        upd;
   logic [2:0]  upd_step;

   iss_irq_if irq_bus ();

   iss_irq u_irq (
      .clk  (clk),
      .nrst (nrst),
      .bus  (irq_bus)
   );

   // --------------------------------------------------------------
   // register port decode
   // --------------------------------------------------------------
   assign start    = wr_en && (addr == OFS_CMD) && (state_r == S_IDLE);
   assign cause_rd = rd_en && (addr == OFS_CAUSE);

   assign irq_bus.wr_stat = wr_en && (addr == OFS_IST);
   assign irq_bus.wr_mask = wr_en && (addr == OFS_IMASK);
   assign irq_bus.wdata   = wdata[IRQ_W-1:0];

   // --------------------------------------------------------------
   // sequencer next state
   // --------------------------------------------------------------
   function automatic logic is_phase(input logic [2:0] ph,
                                     input logic [2:0] want);
      is_phase = (ph == want);
   endfunction : is_phase

   always_comb begin
      state_nxt = state_r;
      atn_nxt   = atn_r;
      cnt_nxt   = cnt_r;
      fin       = 1'b0;
      fin_step  = STEP_SEL;
      fin_cause = CAUSE_SRSO;
      upd       = 1'b0;
      upd_step  = STEP_SEL;
      if (state_r != S_IDLE && disc_evt) begin
         fin       = 1'b1;                                    // R1
         fin_step  = STEP_SEL;                                // R1
         fin_cause = CAUSE_DISC;                              // R13
         atn_nxt   = 1'b0;
         state_nxt = S_IDLE;
      end else begin
         unique case (state_r)
            S_IDLE: begin
               if (start) begin
                  state_nxt = S_SEL;
                  atn_nxt   = (wdata[1:0] != ISS_PLAIN);
                  cnt_nxt   = 2'h0;
                  upd       = 1'b1;
                  upd_step  = STEP_SEL;
               end else if (disc_evt) begin
                  // a disconnect while idle drops a held attention
                  atn_nxt   = 1'b0;
               end
            end
            S_SEL: begin
               if (sel_done) begin
                  if (kind_r == ISS_PLAIN) begin
                     state_nxt = S_CMDW;
                     upd       = 1'b1;                        // R11
                     upd_step  = STEP_MSG;                    // R4
                  end else begin
                     state_nxt = S_MSGW;
                  end
               end
            end
            S_MSGW: begin
               if (req_evt) begin
                  if (is_phase(bus_phase, PH_MSGOUT)) begin
                     state_nxt = S_MSG;
                  end else begin
                     fin       = 1'b1;                        // R6 R9 R10
                     fin_step  = STEP_SEL;                    // R6 R9 R10
                     state_nxt = S_IDLE;
                  end
               end
            end
            S_MSG: begin
               if (byte_sent) begin
                  cnt_nxt = cnt_r + 2'h1;
                  if (kind_r == ISS_STOP) begin
                     fin       = 1'b1;
                     fin_step  = STEP_STOP;
                     state_nxt = S_IDLE;
                  end else if (kind_r == ISS_ATN ||
                               cnt_nxt == MSG3_BYTES) begin
                     atn_nxt   = 1'b0;                        // R5 R8
                     state_nxt = S_CMDW;
                     upd       = 1'b1;                        // R11
                     upd_step  = STEP_MSG;
                  end
               end else if (req_evt &&
                            !is_phase(bus_phase, PH_MSGOUT)) begin
                  fin       = 1'b1;                           // R8
                  fin_step  = STEP_MSG;                       // R8
                  state_nxt = S_IDLE;
               end
            end
            S_CMDW: begin
               if (req_evt) begin
                  if (is_phase(bus_phase, PH_CMD)) begin
                     state_nxt = S_CMD;
                     upd       = 1'b1;                        // R11
                     upd_step  = STEP_CMD;
                  end else begin
                     fin       = 1'b1;                        // R4 R5 R8
                     fin_step  = STEP_MSG;                    // R4 R5 R8
                     state_nxt = S_IDLE;
                  end
               end
            end
            S_CMD: begin
               if (byte_sent && cdb_last) begin
                  fin       = 1'b1;                           // R2 R7
                  fin_step  = STEP_DONE;                      // R2 R7
                  state_nxt = S_IDLE;
               end else if (req_evt &&
                            !is_phase(bus_phase, PH_CMD)) begin
                  fin       = 1'b1;                           // R3
                  fin_step  = STEP_CMD;                       // R3
                  state_nxt = S_IDLE;
               end
            end
            default: begin
               // illegal state code: back to idle
               state_nxt = S_IDLE;
            end
         endcase
      end
   end

   // --------------------------------------------------------------
   // sequencer state
   // --------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= S_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         kind_r <= ISS_PLAIN;
      end else if (start) begin
         kind_r <= iss_kind_e'(wdata[1:0]);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 2'h0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // attention stays driven after a halt until the next disconnect or the next start of a plain selection
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         atn_r <= 1'b0;
      end else begin
         atn_r <= atn_nxt;                                    // R6 R9 R10
      end
   end

   // --------------------------------------------------------------
   // reported status; a report in the clearing cycle wins
   // --------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         step_r <= RST_STEP;
      end else if (fin) begin
         step_r <= fin_step;                                  // R14
      end else if (upd) begin
         step_r <= upd_step;                                  // R11
      end else if (cause_rd) begin
         step_r <= RST_STEP;                                  // R12
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cause_r <= RST_BYTE;
      end else if (fin) begin
         cause_r <= fin_cause;                                // R14
      end else if (cause_rd) begin
         cause_r <= RST_BYTE;                                 // R12
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         main_r <= RST_BYTE;
      end else if (fin) begin
         main_r <= {1'b1, 4'h0, bus_phase};
      end else if (cause_rd) begin
         main_r <= RST_BYTE;                                  // R12
      end
   end

   // --------------------------------------------------------------
   // interrupt events
   // --------------------------------------------------------------
   // one word of events, disconnect above sequence end
   assign irq_bus.evt = {fin && fin_cause[5], fin};           // R13 R14

   // --------------------------------------------------------------
   // read data, valid the cycle after the read strobe only
   // --------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= RST_BYTE;
      end else if (rd_en) begin
         unique case (addr)
            OFS_CMD: begin
               rdata <= {(state_r != S_IDLE), 5'h00, kind_r};
            end
            OFS_MAIN: begin
               rdata <= main_r;
            end
            OFS_CAUSE: begin
               rdata <= cause_r;
            end
            OFS_STEP: begin
               rdata <= {5'h00, step_r};
            end
            OFS_IST: begin
               rdata <= {6'h00, irq_bus.stat};
            end
            OFS_IMASK: begin
               rdata <= {6'h00, irq_bus.mask};
            end
            default: begin
               rdata <= RST_BYTE;
            end
         endcase
      end else begin
         rdata <= RST_BYTE;
      end
   end

   assign atn_o  = atn_r;
   assign busy_o = (state_r != S_IDLE);
   assign irq_o  = irq_bus.irq;
endmodule : iss_top
`default_nettype wire

//--- sim/iss_top_assertions.sv
// port-level assertions for the selection status block
// assumes bound into iss_top, single clock domain
`timescale 1ns/1ps
`default_nettype none
module iss_top_assertions
   import iss_pkg::*;
(
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] rdata,
   input wire logic       disc_evt,
   input wire logic       req_evt,
   input wire logic [2:0] bus_phase,
   input wire logic       byte_sent,
   input wire logic       cdb_last,
   input wire logic       atn_o,
   input wire logic       busy_o,
   input wire logic       irq_o
);
   // ------
   // helper state
   // ------
   iss_kind_e  kind_r;
   logic [1:0] cnt_r;
   logic [1:0] mask_r;
   logic       disc_r;
   logic       start;
   assign start = wr_en && addr == OFS_CMD && !busy_o;
   // kind of running sequence, message bytes sent under attention
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         kind_r <= ISS_PLAIN;
         cnt_r  <= 2'h0;
      end else if (start) begin
         kind_r <= iss_kind_e'(wdata[1:0]);
         cnt_r  <= 2'h0;
      end else if (busy_o && byte_sent && atn_o) begin
         cnt_r <= cnt_r + 2'h1;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) mask_r <= 2'h0;
      else if (wr_en && addr == OFS_IMASK) mask_r <= wdata[1:0];
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) disc_r <= 1'b0;
      else if (busy_o && disc_evt) disc_r <= 1'b1;
      else if (start || (rd_en && addr == OFS_CAUSE)) disc_r <= 1'b0;
   end
   // ------
   // assertions
   // ------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_disc_ends_seq: assert property (
      busy_o && disc_evt |=> !busy_o) else $error("disconnect kept busy");
   a_last_cmd_done: assert property (
      busy_o && byte_sent && cdb_last && !atn_o |=> !busy_o)
      else $error("last command byte did not end sequence");
   a_atn_one_byte: assert property (
      busy_o && kind_r == ISS_ATN && byte_sent && atn_o |=> !atn_o)
      else $error("attention kept after message byte");
   a_atn_three_bytes: assert property (
      busy_o && kind_r == ISS_ATN3 && byte_sent && atn_o
      |=> atn_o == (cnt_r != 2'h3)) else $error("attention release count");
   a_halt_keeps_atn: assert property (
      busy_o && atn_o && req_evt && bus_phase != PH_MSGOUT &&
      kind_r != ISS_PLAIN && cnt_r == 2'h0 |=> atn_o && !busy_o)
      else $error("halt without message out lost attention");
   a_read_clears_step: assert property (
      rd_en && addr == OFS_CAUSE && !busy_o ##1
      rd_en && addr == OFS_STEP && !busy_o |=> rdata == 8'h00)
      else $error("step not cleared by cause read");
   a_disc_flag_set: assert property (
      rd_en && addr == OFS_CAUSE && disc_r && !busy_o |=> rdata[5])
      else $error("disconnect flag missing");
   a_irq_with_end: assert property (
      $fell(busy_o) && mask_r == 2'h3 |-> irq_o)
      else $error("interrupt late at sequence end");
endmodule : iss_top_assertions

bind iss_top iss_top_assertions iss_top_assertions_i (
   .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
   .rd_en(rd_en), .rdata(rdata), .disc_evt(disc_evt), .req_evt(req_evt),
   .bus_phase(bus_phase), .byte_sent(byte_sent), .cdb_last(cdb_last),
   .atn_o(atn_o), .busy_o(busy_o), .irq_o(irq_o));
`default_nettype wire

//--- sim/iss_target.sv
// behavioural target on the far side of the selection sequencer
// assumes its one-cycle pulses are sampled on the rising clk edge
`timescale 1ns/1ps
`default_nettype none
module iss_target (
   input  wire logic       clk,
   output var  logic       sel_done,
   output var  logic       disc_evt,
   output var  logic       req_evt,
   output var  logic [2:0] bus_phase,
   output var  logic       byte_sent,
   output var  logic       cdb_last
);
   initial begin
      sel_done  = 1'b0;
      disc_evt  = 1'b0;
      req_evt   = 1'b0;
      bus_phase = 3'h5;
      byte_sent = 1'b0;
      cdb_last  = 1'b1;
   end
   // ------
   // pulses; qualifiers go to the inverse value once released
   // ------
   // one event cycle: {sel, disc, req, sent} pulses with their qualifiers
   task pulse(input logic [3:0] ev, input logic [2:0] ph, input logic last);
      @(posedge clk) {sel_done, disc_evt, req_evt, byte_sent} <= ev;
      bus_phase <= ph;
      cdb_last  <= last;
      @(posedge clk) {sel_done, disc_evt, req_evt, byte_sent} <= 4'h0;
      bus_phase <= ~ph;
      cdb_last  <= ~last;
   endtask : pulse
   task sel();
      pulse(4'h8, bus_phase, cdb_last);
   endtask : sel
   task disc();
      pulse(4'h4, bus_phase, cdb_last);
   endtask : disc
   task req(input logic [2:0] ph);
      pulse(4'h2, ph, cdb_last);
   endtask : req
   task send(input logic last);
      pulse(4'h1, bus_phase, last);
   endtask : send
endmodule : iss_target
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the selection status block
// assumes iss_target drives the bus events
`timescale 1ns/1ps
`default_nettype none
module tb
   import iss_pkg::*;
;
   logic       clk, nrst, wr_en, rd_en, atn_o, busy_o, irq_o;
   logic       sel_done, disc_evt, req_evt, byte_sent, cdb_last;
   logic [7:0] addr, wdata, rdata;
   logic [2:0] bus_phase;
   int         errors, checked, k;

   iss_top iss_top_i (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sel_done(sel_done),
      .disc_evt(disc_evt), .req_evt(req_evt), .bus_phase(bus_phase),
      .byte_sent(byte_sent), .cdb_last(cdb_last), .atn_o(atn_o),
      .busy_o(busy_o), .irq_o(irq_o));
   iss_target iss_target_i (.clk(clk), .sel_done(sel_done),
      .disc_evt(disc_evt), .req_evt(req_evt), .bus_phase(bus_phase),
      .byte_sent(byte_sent), .cdb_last(cdb_last));

   always #4 clk = ~clk;
   // ------
   // tasks
   // ------
   task stop_test();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   task chk8(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask : chk8
   task chkb(input logic g, input logic e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask : chkb
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) wr_en <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk) wr_en <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk) rd_en <= 1'b1;
      addr <= a;
      @(posedge clk) rd_en <= 1'b0;
      @(negedge clk) chk8(rdata, e);
   endtask : rd
   // step, cause, step again back to back
   task report(input logic [2:0] es, input logic [7:0] ec);
      @(posedge clk) rd_en <= 1'b1;
      addr <= OFS_STEP;
      @(posedge clk) addr <= OFS_CAUSE;
      @(negedge clk) chk8(rdata, {5'h00, es});
      @(posedge clk) addr <= OFS_STEP;
      @(negedge clk) chk8(rdata, ec);
      @(posedge clk) rd_en <= 1'b0;
      @(negedge clk) chk8(rdata, 8'h00);
      $display("test done step %0h cause %h", es, ec);
   endtask : report
   // ------
   // tests
   // ------
   initial begin
      #20000 errors++;
      stop_test();
   end
   initial begin
      {clk, nrst, wr_en, rd_en} = 4'h0;
      {addr, wdata} = 16'h0000;
      errors = 0;
      checked = 0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rd(8'h0f, 8'h00);
      wr(OFS_IMASK, 8'h03);
      wr(OFS_CMD, 8'h01);
      @(negedge clk) chkb(busy_o, 1'b1);
      iss_target_i.sel();
      iss_target_i.req(PH_MSGOUT);
      iss_target_i.send(1'b0);
      @(negedge clk) chkb(atn_o, 1'b0);
      rd(OFS_STEP, 8'h02);
      iss_target_i.req(PH_CMD);
      iss_target_i.send(1'b0);
      iss_target_i.send(1'b1);
      @(negedge clk) chkb(irq_o, 1'b1);
      chkb(busy_o, 1'b0);
      report(STEP_DONE, CAUSE_SRSO);
      wr(OFS_IST, 8'h03);
      @(negedge clk) chkb(irq_o, 1'b0);
      wr(OFS_CMD, 8'h01);
      iss_target_i.sel();
      iss_target_i.req(PH_MSGOUT);
      iss_target_i.send(1'b0);
      iss_target_i.req(PH_CMD);
      iss_target_i.send(1'b0);
      iss_target_i.req(PH_MSGOUT);
      report(STEP_CMD, CAUSE_SRSO);
      wr(OFS_CMD, 8'h01);
      iss_target_i.sel();
      iss_target_i.req(PH_MSGOUT);
      iss_target_i.send(1'b0);
      iss_target_i.req(PH_MSGOUT);
      report(STEP_MSG, CAUSE_SRSO);
      wr(OFS_CMD, 8'h00);
      iss_target_i.sel();
      iss_target_i.req(PH_MSGOUT);
      @(negedge clk) chkb(atn_o, 1'b0);
      rd(OFS_MAIN, {1'b1, 4'h0, PH_MSGOUT});
      report(STEP_MSG, CAUSE_SRSO);
      rd(OFS_MAIN, 8'h00);
      for (k = 1; k < 4; k++) begin
         wr(OFS_CMD, 8'(k));
         iss_target_i.sel();
         iss_target_i.req(PH_CMD);
         @(negedge clk) chkb(atn_o, 1'b1);
         report(STEP_SEL, CAUSE_SRSO);
         iss_target_i.disc();
         @(negedge clk) chkb(atn_o, 1'b0);
      end
      wr(OFS_CMD, 8'h03);
      rd(OFS_CMD, 8'h83);
      iss_target_i.sel();
      iss_target_i.req(PH_MSGOUT);
      iss_target_i.send(1'b0);
      @(negedge clk) chkb(atn_o, 1'b1);
      report(STEP_STOP, CAUSE_SRSO);
      iss_target_i.disc();
      wr(OFS_CMD, 8'h02);
      iss_target_i.sel();
      iss_target_i.req(PH_MSGOUT);
      for (k = 0; k < 3; k++) begin
         iss_target_i.send(1'b0);
         @(negedge clk) chkb(atn_o, k < 2);
      end
      iss_target_i.req(PH_CMD);
      iss_target_i.send(1'b1);
      report(STEP_DONE, CAUSE_SRSO);
      wr(OFS_CMD, 8'h02);
      iss_target_i.sel();
      iss_target_i.req(PH_MSGOUT);
      iss_target_i.send(1'b0);
      iss_target_i.req(PH_CMD);
      @(negedge clk) chkb(atn_o, 1'b1);
      report(STEP_MSG, CAUSE_SRSO);
      iss_target_i.disc();
      wr(OFS_IST, 8'h03);
      wr(OFS_CMD, 8'h01);
      iss_target_i.sel();
      iss_target_i.disc();
      @(negedge clk) chkb(irq_o, 1'b1);
      report(STEP_SEL, CAUSE_DISC);
      rd(OFS_IST, 8'h03);
      wr(OFS_IMASK, 8'h00);
      @(negedge clk) chkb(irq_o, 1'b0);
      wr(OFS_IST, 8'h03);
      rd(OFS_IST, 8'h00);
      stop_test();
   end
endmodule : tb
`default_nettype wire
